// file: rtl/aws_pkg.sv
// Constants and types for the arbitrary waveform sequencer
//----------------------------------------------------------------------
// Contract
// - Table of 99 points, each with the same independently configured parameter set.
// - Whole generator drives voltage or current only, never a mix.
// - Each point outputs a linear DC ramp plus a swept sine overlay.
// - Start and end frequency both zero: sine adds nothing, DC ramp only.
// - Each point runs its own duration, 0.1 ms to 36,000,000 ms.
// - AC start and end amplitudes lie between zero and half nominal.
// - DC start/end lie between AC amplitude and nominal minus AC amplitude.
// - Start and end frequencies lie between zero and 10000 Hz.
// - Start angle is whole degrees, 0 to 359.
// - Reject a point whose frequency change per second is below 9.3.
// - Reject a point whose amplitude change is too small for its duration.
// - Block runs 1 to 999 cycles; zero repeats it forever.
// - Block spans first index 1..last and last index first..99.
// - Only tables tagged for the current assignment are accepted.
// - Loaded rows are range-checked; a failing row is reported, not stored.
//----------------------------------------------------------------------
package aws_pkg;
  localparam int N_PTS = 99;
  localparam int AMP_W = 16;
  localparam int FRQ_W = 14;
  localparam int ANG_W = 9;
  localparam int DUR_W = 29;
  localparam int CYC_W = 10;
  localparam int IDX_W = 7;
  localparam int FRAC_W = 32;
  localparam int ACC_W = 49;
  localparam int DIV_W = 48;
  localparam logic [AMP_W-1:0] NOM_DEF = 16'hc350;
  // Time base
  localparam int CLK_NS = 40;
  localparam int TICK_US = 100;
  localparam int TICK_CYC = (TICK_US * 1000) / CLK_NS;
  localparam int TICK_HZ = 1000000 / TICK_US;
  localparam longint TIME_MAX_MS = 36000000;
  localparam logic [DUR_W-1:0] DUR_MIN = 29'h0000001;
  localparam logic [DUR_W-1:0] DUR_MAX = DUR_W'((TIME_MAX_MS * 1000) / TICK_US);
  // Limits
  localparam logic [FRQ_W-1:0] FRQ_MAX = 14'h2710;
  localparam logic [ANG_W-1:0] ANG_MAX = 9'h167;
  localparam logic [CYC_W-1:0] CYC_MAX = 10'h3e7;
  localparam logic [IDX_W-1:0] IDX_MAX = 7'h63;
  localparam logic [IDX_W-1:0] IDX_MIN = 7'h01;
  localparam longint DF_NUM = 93;
  localparam longint DF_DEN = 10;
  localparam longint AMP_MIN_RATE = 1;
  localparam logic [31:0] PH_PER_HZ = 32'((64'd1 << 32) / 64'(TICK_HZ));
  localparam logic [31:0] PH_PER_DEG = 32'((64'd1 << 32) / 64'd360);
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CFG = 8'h04;
  localparam logic [7:0] OFF_BLOCK = 8'h08;
  localparam logic [7:0] OFF_CYCLES = 8'h0c;
  localparam logic [7:0] OFF_STAT = 8'h10;
  localparam logic [7:0] OFF_MASK = 8'h14;
  localparam logic [7:0] OFF_SEL = 8'h18;
  localparam logic [7:0] OFF_AC = 8'h1c;
  localparam logic [7:0] OFF_DC = 8'h20;
  localparam logic [7:0] OFF_FREQ = 8'h24;
  localparam logic [7:0] OFF_ANGLE = 8'h28;
  localparam logic [7:0] OFF_TIME = 8'h2c;
  localparam logic [7:0] OFF_CMT = 8'h30;
  localparam logic [7:0] OFF_POS = 8'h34;
  localparam logic [7:0] OFF_OUT = 8'h38;
  // Field positions
  localparam int CTRL_START = 0;
  localparam int CTRL_STOP = 1;
  localparam int CMT_GO = 0;
  localparam int CMT_TAG = 1;
  localparam int ST_REJ = 0;
  localparam int ST_CFG = 1;
  localparam int ST_DONE = 2;
  localparam int ST_OK = 3;
  localparam int N_ST = 4;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOAD = 2'b01,
    ST_DIV = 2'b11,
    ST_RUN = 2'b10
  } aws_state_t;
endpackage

// file: rtl/aws_top.sv
// Arbitrary waveform sequencer: point table, checks, block runner and setpoint generator
`timescale 1ns/1ps
module aws_top
  import aws_pkg::*;
#(
  parameter logic [AMP_W-1:0] NOMINAL = NOM_DEF,
  parameter int TICK_CYCLES = TICK_CYC
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // Setpoint to power stage
  output logic [AMP_W-1:0] setpoint_o,
  output logic setpoint_cur_o,
  output logic setpoint_upd_o,
  output logic running_o,
  // Interrupt
  output logic irq_o
);

  //--------------------------------------------------------------------
  // Declarations
  //--------------------------------------------------------------------
  function automatic logic [AMP_W-1:0] absd(input logic [AMP_W-1:0] a, input logic [AMP_W-1:0] b);
    absd = (a > b) ? a - b : b - a;
  endfunction

  aws_state_t st_ff;
  logic cfg_cur_ff;
  logic [IDX_W-1:0] first_ff, last_ff, sel_ff, cur_ff;
  logic [CYC_W-1:0] cycles_ff, cyc_done_ff;
  logic [N_ST-1:0] stat_ff, mask_ff, ev;
  logic [AMP_W-1:0] s_acs_ff, s_ace_ff, s_dcs_ff, s_dce_ff;
  logic [FRQ_W-1:0] s_fs_ff, s_fe_ff;
  logic [ANG_W-1:0] s_ang_ff;
  logic [DUR_W-1:0] s_dur_ff;
  logic [31:0] rdata_ff, rd_mux;
  logic [AMP_W-1:0] setpoint_ff;
  logic upd_ff, irq_ff, running_ff;
  logic [15:0] tick_cnt_ff;
  logic tick;

  // Point table
  logic [AMP_W-1:0] t_acs [N_PTS];
  logic [AMP_W-1:0] t_ace [N_PTS];
  logic [AMP_W-1:0] t_dcs [N_PTS];
  logic [AMP_W-1:0] t_dce [N_PTS];
  logic [FRQ_W-1:0] t_fs [N_PTS];
  logic [FRQ_W-1:0] t_fe [N_PTS];
  logic [ANG_W-1:0] t_ang [N_PTS];
  logic [DUR_W-1:0] t_dur [N_PTS];

  // Run datapath: index 0 DC level, 1 sine amplitude, 2 frequency
  logic signed [ACC_W-1:0] acc_ff [3];
  logic signed [ACC_W-1:0] rate_ff [3];
  logic signed [AMP_W:0] dlt_ff [3];
  logic [AMP_W-1:0] ld_s [3];
  logic [AMP_W-1:0] ld_e [3];
  logic [31:0] ph_ff;
  logic [DUR_W-1:0] dur_ff, t_ff;
  logic ac_on_ff;
  logic [IDX_W-1:0] ra;

  // Divider
  logic [1:0] div_sel_ff;
  logic [5:0] div_cnt_ff;
  logic [DUR_W-1:0] div_rem_ff;
  logic [DIV_W-1:0] div_quo_ff;
  logic div_neg_ff, div_done;
  logic [DUR_W:0] rem_sh;
  logic rem_ge;

  // Decode and checks
  logic wr_ctrl, wr_cmt, start_req, stop_req, cmt_req, blk_ok, pt_ok, df_ok, da_ok, pt_end, blk_end;
  logic [AMP_W-1:0] half_nom, df, dac, ddc;

  //--------------------------------------------------------------------
  // Register writes
  //--------------------------------------------------------------------
  assign wr_ctrl = reg_wr_i && (reg_addr_i == OFF_CTRL);
  assign wr_cmt = reg_wr_i && (reg_addr_i == OFF_CMT);
  assign start_req = wr_ctrl && reg_wdata_i[CTRL_START];
  assign stop_req = wr_ctrl && reg_wdata_i[CTRL_STOP];
  assign cmt_req = wr_cmt && reg_wdata_i[CMT_GO];

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cfg_cur_ff <= 1'b0;
      first_ff <= IDX_MIN;
      last_ff <= IDX_MIN;
      cycles_ff <= 10'h001;
      mask_ff <= '0;
      sel_ff <= IDX_MIN;
      s_acs_ff <= '0;
      s_ace_ff <= '0;
      s_dcs_ff <= '0;
      s_dce_ff <= '0;
      s_fs_ff <= '0;
      s_fe_ff <= '0;
      s_ang_ff <= '0;
      s_dur_ff <= DUR_MIN;
    end else if (reg_wr_i) begin
      unique case (reg_addr_i)
        // Assignment is frozen while running so the output never switches quantity mid-curve
        OFF_CFG: if (st_ff == ST_IDLE) cfg_cur_ff <= reg_wdata_i[0];
        OFF_BLOCK: begin
          first_ff <= reg_wdata_i[6:0];
          last_ff <= reg_wdata_i[14:8];
        end
        OFF_CYCLES: cycles_ff <= reg_wdata_i[9:0];
        OFF_MASK: mask_ff <= reg_wdata_i[N_ST-1:0];
        OFF_SEL: sel_ff <= reg_wdata_i[6:0];
        OFF_AC: begin
          s_acs_ff <= reg_wdata_i[15:0];
          s_ace_ff <= reg_wdata_i[31:16];
        end
        OFF_DC: begin
          s_dcs_ff <= reg_wdata_i[15:0];
          s_dce_ff <= reg_wdata_i[31:16];
        end
        OFF_FREQ: begin
          s_fs_ff <= reg_wdata_i[13:0];
          s_fe_ff <= reg_wdata_i[29:16];
        end
        OFF_ANGLE: s_ang_ff <= reg_wdata_i[8:0];
        OFF_TIME: s_dur_ff <= reg_wdata_i[28:0];
        default: ;
      endcase
    end
  end

  //--------------------------------------------------------------------
  // Plausibility checks
  //--------------------------------------------------------------------
  assign half_nom = NOMINAL >> 1;
  assign df = absd(16'(s_fs_ff), 16'(s_fe_ff));
  assign dac = absd(s_acs_ff, s_ace_ff);
  assign ddc = absd(s_dcs_ff, s_dce_ff);
  // An unchanged frequency is exempt; only a sweep has a minimum rate
  assign df_ok = (df == 16'h0000) ||
                 (64'(df) * 64'(TICK_HZ) * 64'(DF_DEN) >= 64'(DF_NUM) * 64'(s_dur_ff));
  assign da_ok = ((dac | ddc) == 16'h0000) ||
                 (64'((dac > ddc) ? dac : ddc) * 64'(TICK_HZ) >= 64'(AMP_MIN_RATE) * 64'(s_dur_ff));

  always_comb begin
    pt_ok = 1'b1;
    if (sel_ff < IDX_MIN || sel_ff > IDX_MAX) pt_ok = 1'b0;
    if (s_acs_ff > half_nom || s_ace_ff > half_nom) pt_ok = 1'b0;
    if (s_dcs_ff < s_acs_ff || s_dcs_ff > NOMINAL - s_acs_ff) pt_ok = 1'b0;
    if (s_dce_ff < s_ace_ff || s_dce_ff > NOMINAL - s_ace_ff) pt_ok = 1'b0;
    if (s_fs_ff > FRQ_MAX || s_fe_ff > FRQ_MAX) pt_ok = 1'b0;
    if (s_ang_ff > ANG_MAX) pt_ok = 1'b0;
    if (s_dur_ff < DUR_MIN || s_dur_ff > DUR_MAX) pt_ok = 1'b0;
    if (!df_ok || !da_ok) pt_ok = 1'b0;
    if (reg_wdata_i[CMT_TAG] != cfg_cur_ff) pt_ok = 1'b0;
    if (st_ff != ST_IDLE) pt_ok = 1'b0;
  end

  assign blk_ok = (first_ff >= IDX_MIN) && (first_ff <= last_ff) && (last_ff <= IDX_MAX) &&
                  (cycles_ff <= CYC_MAX) && (st_ff == ST_IDLE);

  //--------------------------------------------------------------------
  // Point table store
  //--------------------------------------------------------------------
  // A rejected row leaves the stored point untouched
  always_ff @(posedge ref_clk_i) begin
    if (cmt_req && pt_ok) begin
      t_acs[sel_ff - IDX_MIN] <= s_acs_ff;
      t_ace[sel_ff - IDX_MIN] <= s_ace_ff;
      t_dcs[sel_ff - IDX_MIN] <= s_dcs_ff;
      t_dce[sel_ff - IDX_MIN] <= s_dce_ff;
      t_fs[sel_ff - IDX_MIN] <= s_fs_ff;
      t_fe[sel_ff - IDX_MIN] <= s_fe_ff;
      t_ang[sel_ff - IDX_MIN] <= s_ang_ff;
      t_dur[sel_ff - IDX_MIN] <= s_dur_ff;
    end
  end

  assign ra = cur_ff - IDX_MIN;
  assign ld_s[0] = t_dcs[ra];
  assign ld_e[0] = t_dce[ra];
  assign ld_s[1] = t_acs[ra];
  assign ld_e[1] = t_ace[ra];
  assign ld_s[2] = 16'(t_fs[ra]);
  assign ld_e[2] = 16'(t_fe[ra]);

  //--------------------------------------------------------------------
  // Sequencer state
  //--------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tick_cnt_ff <= '0;
    end else begin
      tick_cnt_ff <= tick ? 16'h0000 : tick_cnt_ff + 16'h0001;
    end
  end
  assign tick = (tick_cnt_ff == 16'(TICK_CYCLES - 1));

  assign pt_end = (st_ff == ST_RUN) && tick && (t_ff == dur_ff - DUR_MIN);
  assign blk_end = pt_end && (cur_ff == last_ff) && (cycles_ff != 10'h000) &&
                   (cyc_done_ff + 10'h001 == cycles_ff);

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_ff <= ST_IDLE;
      running_ff <= 1'b0;
      cur_ff <= IDX_MIN;
      cyc_done_ff <= '0;
    end else if (stop_req) begin
      st_ff <= ST_IDLE;
      running_ff <= 1'b0;
    end else begin
      unique case (st_ff)
        ST_IDLE: if (start_req && blk_ok) begin
          st_ff <= ST_LOAD;
          running_ff <= 1'b1;
          cur_ff <= first_ff;
          cyc_done_ff <= '0;
        end
        ST_LOAD: st_ff <= ST_DIV;
        ST_DIV: if (div_done) st_ff <= ST_RUN;
        ST_RUN: if (blk_end) begin
          st_ff <= ST_IDLE;
          running_ff <= 1'b0;
        end else if (pt_end) begin
          st_ff <= ST_LOAD;
          if (cur_ff == last_ff) begin
            // Zero cycles never meets the end test, so the block repeats forever
            cur_ff <= first_ff;
            cyc_done_ff <= cyc_done_ff + 10'h001;
          end else begin
            cur_ff <= cur_ff + 7'h01;
          end
        end
      endcase
    end
  end

  //--------------------------------------------------------------------
  // Slope divider: rate = delta * 2^32 / duration, one quantity at a time
  //--------------------------------------------------------------------
  // About 150 cycles per point; must end well inside one tick period
  assign rem_sh = {div_rem_ff, div_quo_ff[DIV_W-1]};
  assign rem_ge = rem_sh >= {1'b0, dur_ff};
  assign div_done = (div_sel_ff == 2'd2) && (div_cnt_ff == 6'd49);

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      div_sel_ff <= '0;
      div_cnt_ff <= '0;
      div_rem_ff <= '0;
      div_quo_ff <= '0;
      div_neg_ff <= 1'b0;
      for (int k = 0; k < 3; k++) rate_ff[k] <= '0;
    end else if (st_ff != ST_DIV) begin
      div_sel_ff <= '0;
      div_cnt_ff <= '0;
    end else if (div_cnt_ff == 6'd0) begin
      div_rem_ff <= '0;
      div_neg_ff <= dlt_ff[div_sel_ff][AMP_W];
      div_quo_ff <= {(dlt_ff[div_sel_ff][AMP_W] ? AMP_W'(-dlt_ff[div_sel_ff]) : dlt_ff[div_sel_ff][AMP_W-1:0]),
                     32'h00000000};
      div_cnt_ff <= 6'd1;
    end else if (div_cnt_ff == 6'd49) begin
      rate_ff[div_sel_ff] <= div_neg_ff ? -ACC_W'(div_quo_ff) : ACC_W'(div_quo_ff);
      div_sel_ff <= div_sel_ff + 2'd1;
      div_cnt_ff <= '0;
    end else begin
      div_rem_ff <= rem_ge ? DUR_W'(rem_sh - {1'b0, dur_ff}) : DUR_W'(rem_sh);
      div_quo_ff <= {div_quo_ff[DIV_W-2:0], rem_ge};
      div_cnt_ff <= div_cnt_ff + 6'd1;
    end
  end

  //--------------------------------------------------------------------
  // Curve datapath
  //--------------------------------------------------------------------
  logic [15:0] sx, sy;
  logic [AMP_W-1:0] ac_term;
  logic signed [AMP_W+1:0] sum;
  logic [53:0] ph_prod;

  // Parabolic half-wave stands in for the sine: cheap, peak error about 6 %
  always_comb begin
    sx = {1'b0, ph_ff[30:16]};
    sy = 16'((32'(sx) * 32'(16'h8000 - sx)) >> 13);
    ac_term = ac_on_ff ? AMP_W'((32'(acc_ff[1][47:32]) * 32'(sy)) >> 15) : '0;
    sum = ph_ff[31] ? $signed({2'b00, acc_ff[0][47:32]}) - $signed({2'b00, ac_term})
                    : $signed({2'b00, acc_ff[0][47:32]}) + $signed({2'b00, ac_term});
    ph_prod = 54'(acc_ff[2][45:24]) * 54'(PH_PER_HZ);
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int k = 0; k < 3; k++) begin
        acc_ff[k] <= '0;
        dlt_ff[k] <= '0;
      end
      ph_ff <= '0;
      dur_ff <= DUR_MIN;
      t_ff <= '0;
      ac_on_ff <= 1'b0;
      setpoint_ff <= '0;
      upd_ff <= 1'b0;
    end else begin
      upd_ff <= 1'b0;
      if (st_ff == ST_LOAD) begin
        for (int k = 0; k < 3; k++) begin
          acc_ff[k] <= $signed({1'b0, ld_s[k], 32'h00000000});
          dlt_ff[k] <= $signed({1'b0, ld_e[k]}) - $signed({1'b0, ld_s[k]});
        end
        ph_ff <= 32'(32'(t_ang[ra]) * PH_PER_DEG);
        dur_ff <= t_dur[ra];
        t_ff <= '0;
        ac_on_ff <= (t_fs[ra] != '0) || (t_fe[ra] != '0);
      end else if (st_ff == ST_RUN && tick) begin
        if (sum < 0) setpoint_ff <= '0;
        else if (sum > $signed({2'b00, NOMINAL})) setpoint_ff <= NOMINAL;
        else setpoint_ff <= AMP_W'(sum);
        upd_ff <= 1'b1;
        for (int k = 0; k < 3; k++) acc_ff[k] <= acc_ff[k] + rate_ff[k];
        ph_ff <= ph_ff + ph_prod[39:8];
        t_ff <= t_ff + DUR_MIN;
      end
    end
  end

  //--------------------------------------------------------------------
  // Status, interrupt and read port
  //--------------------------------------------------------------------
  always_comb begin
    ev = '0;
    ev[ST_REJ] = cmt_req && !pt_ok;
    ev[ST_OK] = cmt_req && pt_ok;
    ev[ST_CFG] = start_req && !blk_ok;
    ev[ST_DONE] = blk_end;
  end

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      stat_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      if (reg_wr_i && reg_addr_i == OFF_STAT) begin
        stat_ff <= (stat_ff & ~reg_wdata_i[N_ST-1:0]) | ev;
      end else begin
        stat_ff <= stat_ff | ev;
      end
      irq_ff <= |((stat_ff | ev) & mask_ff);
    end
  end

  always_comb begin
    rd_mux = 32'h00000000;
    case (reg_addr_i)
      OFF_CTRL: rd_mux = {31'h0, st_ff != ST_IDLE};
      OFF_CFG: rd_mux = {31'h0, cfg_cur_ff};
      OFF_BLOCK: rd_mux = {17'h0, last_ff, 1'b0, first_ff};
      OFF_CYCLES: rd_mux = {22'h0, cycles_ff};
      OFF_STAT: rd_mux = {28'h0, stat_ff};
      OFF_MASK: rd_mux = {28'h0, mask_ff};
      OFF_SEL: rd_mux = {25'h0, sel_ff};
      OFF_AC: rd_mux = {s_ace_ff, s_acs_ff};
      OFF_DC: rd_mux = {s_dce_ff, s_dcs_ff};
      OFF_FREQ: rd_mux = {2'b00, s_fe_ff, 2'b00, s_fs_ff};
      OFF_ANGLE: rd_mux = {23'h0, s_ang_ff};
      OFF_TIME: rd_mux = {3'h0, s_dur_ff};
      OFF_POS: rd_mux = {6'h0, cyc_done_ff, 9'h0, cur_ff};
      OFF_OUT: rd_mux = {16'h0, setpoint_ff};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) rdata_ff <= '0;
    else rdata_ff <= reg_rd_i ? rd_mux : 32'h00000000;
  end

  assign reg_rdata_o = rdata_ff;
  assign setpoint_o = setpoint_ff;
  assign setpoint_cur_o = cfg_cur_ff;
  assign setpoint_upd_o = upd_ff;
  assign running_o = running_ff;
  assign irq_o = irq_ff;

endmodule

// file: tb/aws_checker.sv
// Port-level assertions for the waveform sequencer
`timescale 1ns/1ps
module aws_checker
  import aws_pkg::*;
#(
  parameter logic [AMP_W-1:0] NOMINAL = NOM_DEF
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  // Setpoint and status
  input wire logic [AMP_W-1:0] setpoint_o,
  input wire logic setpoint_cur_o,
  input wire logic setpoint_upd_o,
  input wire logic running_o,
  input wire logic irq_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  chk_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
    else $error("read data outside its slot");
  chk_unmapped_zero: assert property (reg_rd_i && reg_addr_i > OFF_OUT |=> reg_rdata_o == 32'h0)
    else $error("unmapped read not zero");
  chk_cfg_write: assert property (reg_wr_i && reg_addr_i == OFF_CFG && !running_o
    |=> {31'h0, setpoint_cur_o} == ($past(reg_wdata_i) & 32'h1)) else $error("target select not taken");
  chk_target_frozen: assert property (running_o && $past(running_o) |-> $stable(setpoint_cur_o))
    else $error("target changed while running");
  chk_sp_range: assert property (setpoint_o <= NOMINAL)
    else $error("setpoint above nominal");
  chk_upd_single: assert property (setpoint_upd_o |=> !setpoint_upd_o [*8])
    else $error("update pulses too close");
  chk_sp_hold: assert property ($changed(setpoint_o) |-> setpoint_upd_o)
    else $error("setpoint moved without update");
  chk_upd_running: assert property (setpoint_upd_o |-> $past(running_o))
    else $error("update while idle");
  chk_stop_idle: assert property (reg_wr_i && reg_addr_i == OFF_CTRL && reg_wdata_i[1]
    |-> ##[1:2] !running_o) else $error("stop not obeyed");
  chk_out_read: assert property (reg_rd_i && reg_addr_i == OFF_OUT
    |=> reg_rdata_o == {16'h0, $past(setpoint_o)}) else $error("setpoint readback wrong");
  chk_ctrl_read: assert property (reg_rd_i && reg_addr_i == OFF_CTRL
    |=> reg_rdata_o == {31'h0, $past(running_o)}) else $error("running readback wrong");
endmodule

// file: tb/aws_stage_model.sv
// Power stage model: takes a setpoint sample on each update pulse
`timescale 1ns/1ps
module aws_stage_model
  import aws_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // Setpoint from the sequencer
  input wire logic [AMP_W-1:0] setpoint_i,
  input wire logic setpoint_cur_i,
  input wire logic setpoint_upd_i,
  // Observation
  output int n_samp_o,
  output logic [AMP_W-1:0] last_sp_o,
  output logic last_cur_o
);
  // The stage only latches on the pulse, so a stray setpoint change shows as a wrong last value
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      n_samp_o <= 0;
      last_sp_o <= 16'h0;
      last_cur_o <= 1'b0;
    end else if (setpoint_upd_i) begin
      n_samp_o <= n_samp_o + 1;
      last_sp_o <= setpoint_i;
      last_cur_o <= setpoint_cur_i;
    end
  end
endmodule

// file: tb/arbitrary_waveform_sequencer_bench.sv
// Self-checking bench for the waveform sequencer
`timescale 1ns/1ps
module arbitrary_waveform_sequencer_bench;
  import aws_pkg::*;
  // Short tick keeps each run brief
  localparam int TICKS = 200;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [31:0] reg_rdata_o;
  logic [AMP_W-1:0] setpoint_o;
  logic setpoint_cur_o;
  logic setpoint_upd_o;
  logic running_o;
  logic irq_o;
  int n_samp;
  logic [AMP_W-1:0] last_sp;
  logic last_cur;
  int n_errors = 0;
  int compares = 0;
  int base;
  logic [31:0] rv;
  logic [31:0] rst_val [15] = '{32'h0, 32'h0, 32'h101, 32'h1, 32'h0, 32'h0, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0,
    32'h1, 32'h0, 32'h1, 32'h0};
  logic [31:0] bad_blk [3] = '{32'h0102, 32'h6401, 32'h0100};

  initial begin
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  aws_top #(.TICK_CYCLES(TICKS)) DUT (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .setpoint_o(setpoint_o), .setpoint_cur_o(setpoint_cur_o), .setpoint_upd_o(setpoint_upd_o),
    .running_o(running_o), .irq_o(irq_o));
  aws_stage_model u_stage (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .setpoint_i(setpoint_o),
    .setpoint_cur_i(setpoint_cur_o), .setpoint_upd_i(setpoint_upd_o), .n_samp_o(n_samp), .last_sp_o(last_sp),
    .last_cur_o(last_cur));

  // ----------------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------------
  task automatic tally_and_finish();
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    check(reg_rdata_o, exp);
  endtask
  // Commit the staged point, compare the status, then clear it
  task automatic cm(input logic [31:0] cmt, input logic [31:0] exp);
    wr(OFF_CMT, cmt);
    rdchk(OFF_STAT, exp);
    wr(OFF_STAT, 32'hf);
  endtask
  task automatic pt(input logic [31:0] ac, dc, fq, ang, tm, exp);
    // Row values go out as AC, frequency, angle, DC, then time, all eight per row
    wr(OFF_AC, ac);
    wr(OFF_FREQ, fq);
    wr(OFF_ANGLE, ang);
    wr(OFF_DC, dc);
    wr(OFF_TIME, tm);
    cm(32'h1, exp);
  endtask
  task automatic wait_samp(input int target);
    for (int k = 0; k < 4000 && n_samp < target; k++) @(posedge ref_clk_i);
    if (n_samp < target) begin
      n_errors++;
      tally_and_finish();
    end
  endtask
  task automatic wait_idle();
    for (int k = 0; k < 4000 && running_o !== 1'b0; k++) @(posedge ref_clk_i);
    if (running_o !== 1'b0) begin
      n_errors++;
      tally_and_finish();
    end
  endtask

  // ----------------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (10) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    for (int i = 0; i < 15; i++) begin
      rdchk(8'(i * 4), rst_val[i]);
    end
    rdchk(8'h3c, 32'h0);
    $display("test reset values done");
    // Table rows are loaded while the output is off
    wr(OFF_SEL, 32'h2);
    pt(32'h0, 32'h03e803e8, 32'h0, 32'h0, 32'h3, 32'h8);
    wr(OFF_SEL, 32'h63);
    cm(32'h1, 32'h8);
    wr(OFF_SEL, 32'h0);
    cm(32'h1, 32'h1);
    wr(OFF_SEL, 32'h64);
    cm(32'h1, 32'h1);
    wr(OFF_SEL, 32'h2);
    cm(32'h3, 32'h1);
    pt(32'h61a961a9, 32'h61a961a9, 32'h0, 32'h0, 32'h3, 32'h1);
    pt(32'h61a861a8, 32'h61a861a8, 32'h0, 32'h0, 32'h3, 32'h8);
    pt(32'h03e803e8, 32'h03e803e7, 32'h0, 32'h0, 32'h3, 32'h1);
    pt(32'h03e803e8, 32'hbf6903e8, 32'h0, 32'h0, 32'h3, 32'h1);
    pt(32'h03e803e8, 32'hbf6803e8, 32'h0, 32'h0, 32'h3, 32'h8);
    pt(32'h0, 32'h03e803e8, 32'h27110000, 32'h0, 32'h3, 32'h1);
    pt(32'h0, 32'h03e803e8, 32'h27100000, 32'h0, 32'h3, 32'h8);
    pt(32'h0, 32'h03e803e8, 32'h0, 32'h168, 32'h3, 32'h1);
    pt(32'h0, 32'h03e803e8, 32'h0, 32'h167, 32'h3, 32'h8);
    pt(32'h0, 32'h03e803e8, 32'h000b0001, 32'h0, 32'hc350, 32'h1);
    pt(32'h0, 32'h03e803e8, 32'h000b0001, 32'h0, 32'h2710, 32'h8);
    pt(32'h0, 32'h03e903e8, 32'h0, 32'h0, 32'h4e20, 32'h1);
    pt(32'h0, 32'h03e903e8, 32'h0, 32'h0, 32'h2710, 32'h8);
    pt(32'h0, 32'h03e803e8, 32'h0, 32'h0, 32'h0, 32'h1);
    pt(32'h0, 32'h03e803e8, 32'h0, 32'h0, 32'h15752a00, 32'h8);
    pt(32'h0, 32'h03e803e8, 32'h0, 32'h0, 32'h15752a01, 32'h1);
    $display("test point checks done");
    wr(OFF_SEL, 32'h1);
    // Nonzero amplitude at 90 degrees would lift the output if the zero-frequency rule broke
    pt(32'h01f401f4, 32'h03e803e8, 32'h0, 32'h5a, 32'h3, 32'h8);
    wr(OFF_CYCLES, 32'h2);
    wr(OFF_MASK, 32'h4);
    base = n_samp;
    wr(OFF_CTRL, 32'h1);
    wr(OFF_CFG, 32'h1);
    wr(OFF_CTRL, 32'h1);
    check(32'(irq_o), 32'h0);
    wait_samp(base + 6);
    wait_idle();
    check(32'(n_samp - base), 32'h6);
    check(32'(last_sp), 32'h3e8);
    check(32'(last_cur), 32'h0);
    rdchk(OFF_CFG, 32'h0);
    rdchk(OFF_STAT, 32'h6);
    check(32'(irq_o), 32'h1);
    wr(OFF_STAT, 32'hf);
    rdchk(OFF_STAT, 32'h0);
    check(32'(irq_o), 32'h0);
    $display("test block run done");
    for (int i = 0; i < 3; i++) begin
      wr(OFF_BLOCK, bad_blk[i]);
      wr(OFF_CTRL, 32'h1);
      rdchk(OFF_STAT, 32'h2);
      check(32'(running_o), 32'h0);
      wr(OFF_STAT, 32'hf);
    end
    wr(OFF_BLOCK, 32'h0101);
    $display("test block bounds done");
    wr(OFF_CYCLES, 32'h0);
    base = n_samp;
    wr(OFF_CTRL, 32'h1);
    wait_samp(base + 7);
    check(32'(running_o), 32'h1);
    cm(32'h1, 32'h1);
    wr(OFF_CTRL, 32'h3);
    wait_idle();
    base = n_samp;
    repeat (3 * TICKS) @(posedge ref_clk_i);
    check(32'(n_samp - base), 32'h0);
    check(32'(setpoint_o), 32'h3e8);
    // The start bit beside stop counts as a refused start
    rdchk(OFF_STAT, 32'h2);
    $display("test endless run and stop done");
    wr(OFF_STAT, 32'hf);
    wr(OFF_CFG, 32'h1);
    rdchk(OFF_CFG, 32'h1);
    check(32'(setpoint_cur_o), 32'h1);
    cm(32'h3, 32'h8);
    cm(32'h1, 32'h1);
    $display("test current target done");
    tally_and_finish();
  end
endmodule

bind aws_top aws_checker #(.NOMINAL(NOMINAL)) u_chk (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .setpoint_o(setpoint_o), .setpoint_cur_o(setpoint_cur_o),
  .setpoint_upd_o(setpoint_upd_o), .running_o(running_o), .irq_o(irq_o));
